// >>> shared/ldosw_pkg.sv
// Package for the regulator and load switch enable control block
package ldosw_pkg;
   localparam logic [7:0] REG_REGULATOR_CONFIG = 8'h0B;
   localparam logic [7:0] REG_LOAD_SWITCH_CONFIG = 8'h0C;
   // Field positions
   localparam int SEQ_LSB = 5;
   localparam int PASDSC_BIT = 4;
   localparam int ACTDSC_BIT = 3;
   localparam int EN_LSB = 1;
   localparam int MODE_BIT = 0;
   localparam int SOFT_BIT = 0;
   // Reset values
   localparam logic [1:0] RST_SW_ENABLE = 2'h0;
   localparam logic RST_DISCHARGE = 1'b0;
   localparam logic RST_MODE = 1'b0;
   localparam logic RST_SOFT_START = 1'b0;
   // Sequencing codes
   localparam logic [2:0] SEQ_OFF_A = 3'h0;
   localparam logic [2:0] SEQ_ALWAYS = 3'h1;
   localparam logic [2:0] SEQ_AT_0 = 3'h2;
   localparam logic [2:0] SEQ_AT_25 = 3'h3;
   localparam logic [2:0] SEQ_AT_50 = 3'h4;
   localparam logic [2:0] SEQ_OFF_B = 3'h5;
   localparam logic [2:0] SEQ_PIN = 3'h6;
   localparam logic [2:0] SEQ_SOFTWARE = 3'h7;
   // Software enable values
   localparam logic [1:0] EN_OFF = 2'h0;
   localparam logic [1:0] EN_ON = 2'h1;
   localparam logic [1:0] EN_MPC = 2'h2;
   // Soft start hold time
   localparam int CLK_HZ = 20000000;
   localparam int SOFT_START_MS = 60;
   localparam int SOFT_START_CYCLES = CLK_HZ / 1000 * SOFT_START_MS;
   localparam int SOFT_CNT_W = 22;
   // Boot progress points, in quarters of the delay
   typedef struct packed {
      logic at_0;
      logic at_25;
      logic at_50;
      logic at_100;
   } ldosw_boot_s;
   // Enable inputs of one channel; supply and control pin are shared by both channels
   typedef struct packed {
      logic supply_present;
      logic multipurpose_control_pin;
      logic enable_pin;
   } ldosw_pins_s;
endpackage

// >>> verilog/ldosw_enable_sel.sv
// Enable selection from a sequencing code, used by both channels
`timescale 1ns/100ps
module ldosw_enable_sel (
   input wire logic [2:0] seq_code_i,
   input wire logic [1:0] sw_enable_i,
   input wire ldosw_pkg::ldosw_boot_s boot_i,
   input wire ldosw_pkg::ldosw_pins_s pins_i,
   output logic enable_o
);
   wire sw_req = (sw_enable_i == ldosw_pkg::EN_ON) ||
      ((sw_enable_i == ldosw_pkg::EN_MPC) && pins_i.multipurpose_control_pin);
   // Code 111 waits for the full boot delay; value 11 is reserved and reads as off
   wire soft_en = boot_i.at_100 && sw_req;
   always_comb begin
      case (seq_code_i)
         ldosw_pkg::SEQ_ALWAYS: enable_o = pins_i.supply_present;
         ldosw_pkg::SEQ_AT_0: enable_o = pins_i.supply_present && boot_i.at_0;
         ldosw_pkg::SEQ_AT_25: enable_o = pins_i.supply_present && boot_i.at_25;
         ldosw_pkg::SEQ_AT_50: enable_o = pins_i.supply_present && boot_i.at_50;
         ldosw_pkg::SEQ_PIN: enable_o = pins_i.enable_pin;
         ldosw_pkg::SEQ_SOFTWARE: enable_o = pins_i.supply_present && soft_en;
         default: enable_o = 1'b0;
      endcase
   end
endmodule

// >>> verilog/ldosw_ctrl.sv
// Regulator and load switch enable, discharge, mode latch and soft start control
// Function
// - Regulator code 000 or 101 keeps it off, code 001 keeps it on while supply is present.
// - Regulator codes 010, 011, 100 turn it on at 0, 25 and 50 percent of the boot delay.
// - Regulator code 110 follows its enable pin, code 111 follows software after full delay.
// - Passive discharge on off/hard-reset entry, and while disabled when its bit is 1.
// - Switch mode makes the regulator a plain on/off switch, unregulated, free of UVLO.
// - The mode bit is latched and a new value takes effect only while disabled.
// - Switch code 000 or 101 keeps it off, code 001 keeps it on while supply is present.
// - Switch codes 010, 011, 100 close it at 0, 25 and 50 percent of the boot delay.
// - Switch code 110 follows its enable pin, code 111 follows software after full delay.
// - Switch software field: 00 off, 01 on, 10 on while control pin high, 11 reserved.
// - With soft start set, a 25mA limit holds for 60ms after the switch is enabled.
//
// Chosen here: the plain strobed port.
`timescale 1ns/100ps
module ldosw_ctrl (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   input wire logic [2:0] regulator_sequence_code_i,
   input wire logic [2:0] load_switch_sequence_code_i,
   input wire ldosw_pkg::ldosw_boot_s boot_i,
   input wire logic supply_present_i,
   input wire logic multipurpose_control_pin_i,
   input wire logic regulator_enable_pin_i,
   input wire logic load_switch_enable_pin_i,
   input wire logic off_entry_i,
   output logic regulator_enable_o,
   output logic regulator_switch_mode_o,
   output logic regulator_uvlo_bypass_o,
   output logic regulator_passive_discharge_o,
   output logic regulator_active_discharge_o,
   output logic load_switch_enable_o,
   output logic load_switch_current_limit_o
);
   ////////////////////////////////////////////////////////////////////////
   // Register file
   logic regulator_passive_discharge_q;
   logic regulator_active_discharge_q;
   logic [1:0] regulator_sw_enable_q;
   logic mode_req_q;
   logic [1:0] load_switch_sw_enable_q;
   logic load_switch_soft_start_q;
   logic [7:0] rdata_q;

   wire sel_reg = addr_i == ldosw_pkg::REG_REGULATOR_CONFIG;
   wire sel_sw = addr_i == ldosw_pkg::REG_LOAD_SWITCH_CONFIG;
   wire wr_reg = wr_i && sel_reg;
   wire wr_sw = wr_i && sel_sw;

   wire [7:0] reg_view = {regulator_sequence_code_i, regulator_passive_discharge_q,
      regulator_active_discharge_q, regulator_sw_enable_q, regulator_switch_mode_o};
   wire [7:0] sw_view = {load_switch_sequence_code_i, 2'h0, load_switch_sw_enable_q,
      load_switch_soft_start_q};
   wire [7:0] rdata_d = !rd_i ? rdata_q : sel_reg ? reg_view : sel_sw ? sw_view : 8'h00;

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         regulator_passive_discharge_q <= ldosw_pkg::RST_DISCHARGE;
         regulator_active_discharge_q <= ldosw_pkg::RST_DISCHARGE;
         regulator_sw_enable_q <= ldosw_pkg::RST_SW_ENABLE;
         mode_req_q <= ldosw_pkg::RST_MODE;
      end else if (wr_reg) begin
         regulator_passive_discharge_q <= wdata_i[ldosw_pkg::PASDSC_BIT];
         regulator_active_discharge_q <= wdata_i[ldosw_pkg::ACTDSC_BIT];
         regulator_sw_enable_q <= wdata_i[ldosw_pkg::EN_LSB +: 2];
         mode_req_q <= wdata_i[ldosw_pkg::MODE_BIT];
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         load_switch_sw_enable_q <= ldosw_pkg::RST_SW_ENABLE;
         load_switch_soft_start_q <= ldosw_pkg::RST_SOFT_START;
      end else if (wr_sw) begin
         load_switch_sw_enable_q <= wdata_i[ldosw_pkg::EN_LSB +: 2];
         load_switch_soft_start_q <= wdata_i[ldosw_pkg::SOFT_BIT];
      end
   end

   // Read data only stand in the cycle after the strobe
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= rd_i ? rdata_d : 8'h00;
      end
   end
   assign rdata_o = rdata_q;

   ////////////////////////////////////////////////////////////////////////
   // Enable selection
   logic reg_en;
   logic sw_en;
   ldosw_pkg::ldosw_pins_s reg_pins;
   ldosw_pkg::ldosw_pins_s sw_pins;
   assign reg_pins = '{supply_present: supply_present_i, multipurpose_control_pin: multipurpose_control_pin_i,
      enable_pin: regulator_enable_pin_i};
   assign sw_pins = '{supply_present: supply_present_i, multipurpose_control_pin: multipurpose_control_pin_i,
      enable_pin: load_switch_enable_pin_i};

   ldosw_enable_sel u_reg_sel (
      .seq_code_i(regulator_sequence_code_i),
      .sw_enable_i(regulator_sw_enable_q),
      .boot_i(boot_i),
      .pins_i(reg_pins),
      .enable_o(reg_en)
   );
   ldosw_enable_sel u_sw_sel (
      .seq_code_i(load_switch_sequence_code_i),
      .sw_enable_i(load_switch_sw_enable_q),
      .boot_i(boot_i),
      .pins_i(sw_pins),
      .enable_o(sw_en)
   );

   ////////////////////////////////////////////////////////////////////////
   // Regulator and load switch outputs
   logic reg_en_q;
   logic mode_q;
   logic sw_en_q;
   logic soft_active_q;
   logic [ldosw_pkg::SOFT_CNT_W-1:0] soft_cnt_q;

   // Mode only moves while disabled so the FET never changes role under load
   wire mode_d = reg_en ? mode_q : mode_req_q;
   wire sw_rise = sw_en && !sw_en_q;
   localparam int SOFT_LAST = ldosw_pkg::SOFT_START_CYCLES - 1;
   wire soft_done = soft_cnt_q == SOFT_LAST[ldosw_pkg::SOFT_CNT_W-1:0];

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         reg_en_q <= 1'b0;
         mode_q <= ldosw_pkg::RST_MODE;
         sw_en_q <= 1'b0;
      end else begin
         reg_en_q <= reg_en;
         mode_q <= mode_d;
         sw_en_q <= sw_en;
      end
   end

   // Soft start timer restarts on each closing edge of the switch
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         soft_active_q <= 1'b0;
         soft_cnt_q <= '0;
      end else if (sw_rise && load_switch_soft_start_q) begin
         soft_active_q <= 1'b1;
         soft_cnt_q <= '0;
      end else if (!sw_en || soft_done) begin
         soft_active_q <= 1'b0;
         soft_cnt_q <= '0;
      end else if (soft_active_q) begin
         soft_cnt_q <= soft_cnt_q + 1'b1;
      end
   end

   assign regulator_enable_o = reg_en_q;
   assign regulator_switch_mode_o = mode_q;
   // In switch mode the output is unregulated and ignores undervoltage lockout
   assign regulator_uvlo_bypass_o = mode_q && reg_en_q;
   assign regulator_passive_discharge_o = off_entry_i ||
      (regulator_passive_discharge_q && !reg_en_q);
   assign regulator_active_discharge_o = off_entry_i ||
      (regulator_active_discharge_q && !reg_en_q);
   assign load_switch_enable_o = sw_en_q;
   assign load_switch_current_limit_o = soft_active_q && sw_en_q;

   ////////////////////////////////////////////////////////////////////////
   // Assertions
   AST_REG_OFF_CODES: assert property (@(posedge clk_i) disable iff (srst_i)
      (regulator_sequence_code_i == ldosw_pkg::SEQ_OFF_A ||
       regulator_sequence_code_i == ldosw_pkg::SEQ_OFF_B) ##1
      $stable(regulator_sequence_code_i) |-> !regulator_enable_o)
      else $error("regulator on with off code");
   AST_REG_ALWAYS: assert property (@(posedge clk_i) disable iff (srst_i)
      (regulator_sequence_code_i == ldosw_pkg::SEQ_ALWAYS && supply_present_i)
      |=> regulator_enable_o)
      else $error("regulator off with always code");
   AST_REG_QUARTER: assert property (@(posedge clk_i) disable iff (srst_i)
      (regulator_sequence_code_i == ldosw_pkg::SEQ_AT_25 && supply_present_i)
      |=> regulator_enable_o == $past(boot_i.at_25))
      else $error("regulator not following quarter point");
   AST_REG_PIN: assert property (@(posedge clk_i) disable iff (srst_i)
      regulator_sequence_code_i == ldosw_pkg::SEQ_PIN
      |=> regulator_enable_o == $past(regulator_enable_pin_i))
      else $error("regulator not following enable pin");
   AST_REG_SOFT: assert property (@(posedge clk_i) disable iff (srst_i)
      (regulator_sequence_code_i == ldosw_pkg::SEQ_SOFTWARE && supply_present_i &&
       boot_i.at_100 && regulator_sw_enable_q == ldosw_pkg::EN_MPC)
      |=> regulator_enable_o == $past(multipurpose_control_pin_i))
      else $error("regulator not following control pin");
   AST_DISCHARGE: assert property (@(posedge clk_i) disable iff (srst_i)
      (regulator_passive_discharge_q && !regulator_enable_o) |-> regulator_passive_discharge_o)
      else $error("no passive discharge while disabled");
   AST_ACT_DISCHARGE: assert property (@(posedge clk_i) disable iff (srst_i)
      (!regulator_active_discharge_q && !off_entry_i) |-> !regulator_active_discharge_o)
      else $error("active discharge without cause");
   AST_MODE_HELD: assert property (@(posedge clk_i) disable iff (srst_i)
      (regulator_enable_o && $past(regulator_enable_o)) |-> $stable(regulator_switch_mode_o))
      else $error("mode changed while enabled");
   AST_UVLO: assert property (@(posedge clk_i) disable iff (srst_i)
      regulator_uvlo_bypass_o |-> (regulator_switch_mode_o && regulator_enable_o))
      else $error("bypass outside switch mode");
   AST_SW_PIN: assert property (@(posedge clk_i) disable iff (srst_i)
      load_switch_sequence_code_i == ldosw_pkg::SEQ_PIN
      |=> load_switch_enable_o == $past(load_switch_enable_pin_i))
      else $error("switch not following enable pin");
   AST_SW_OFF: assert property (@(posedge clk_i) disable iff (srst_i)
      (load_switch_sequence_code_i == ldosw_pkg::SEQ_OFF_B) |=> !load_switch_enable_o)
      else $error("switch on with off code");
   AST_SW_HALF: assert property (@(posedge clk_i) disable iff (srst_i)
      (load_switch_sequence_code_i == ldosw_pkg::SEQ_AT_50 && supply_present_i)
      |=> load_switch_enable_o == $past(boot_i.at_50))
      else $error("switch not following half point");
   AST_SW_RESERVED: assert property (@(posedge clk_i) disable iff (srst_i)
      (load_switch_sequence_code_i == ldosw_pkg::SEQ_SOFTWARE &&
       load_switch_sw_enable_q == 2'h3) |=> !load_switch_enable_o)
      else $error("switch on with reserved value");
   AST_SOFT_START: assert property (@(posedge clk_i) disable iff (srst_i)
      (sw_rise && load_switch_soft_start_q) |=> load_switch_current_limit_o)
      else $error("soft start limit missing");
   AST_NO_SOFT: assert property (@(posedge clk_i) disable iff (srst_i)
      (sw_rise && !load_switch_soft_start_q) |=> !load_switch_current_limit_o)
      else $error("limit applied without soft start");
   // The full hold is far too long to run, so it is checked one cycle at a time
   AST_SOFT_HOLD: assert property (@(posedge clk_i) disable iff (srst_i)
      (load_switch_current_limit_o && sw_en && !soft_done) |=> load_switch_current_limit_o)
      else $error("soft start limit dropped early");
   AST_LIMIT_DROP: assert property (@(posedge clk_i) disable iff (srst_i)
      !sw_en |=> !load_switch_current_limit_o)
      else $error("limit held with switch open");
   AST_REG_START: assert property (@(posedge clk_i) disable iff (srst_i)
      (regulator_sequence_code_i == ldosw_pkg::SEQ_AT_0 && supply_present_i)
      |=> regulator_enable_o == $past(boot_i.at_0))
      else $error("regulator not following start point");
   AST_REG_HALF: assert property (@(posedge clk_i) disable iff (srst_i)
      (regulator_sequence_code_i == ldosw_pkg::SEQ_AT_50 && supply_present_i)
      |=> regulator_enable_o == $past(boot_i.at_50))
      else $error("regulator not following half point");
   AST_REG_NO_SUPPLY: assert property (@(posedge clk_i) disable iff (srst_i)
      (regulator_sequence_code_i != ldosw_pkg::SEQ_PIN && !supply_present_i)
      |=> !regulator_enable_o)
      else $error("regulator on without supply");
   AST_REG_SW_ON: assert property (@(posedge clk_i) disable iff (srst_i)
      (regulator_sequence_code_i == ldosw_pkg::SEQ_SOFTWARE && supply_present_i &&
       boot_i.at_100 && regulator_sw_enable_q == ldosw_pkg::EN_ON) |=> regulator_enable_o)
      else $error("regulator off with software enable");
   AST_REG_SW_OFF: assert property (@(posedge clk_i) disable iff (srst_i)
      (regulator_sequence_code_i == ldosw_pkg::SEQ_SOFTWARE &&
       regulator_sw_enable_q == ldosw_pkg::EN_OFF) |=> !regulator_enable_o)
      else $error("regulator on with software disable");
   AST_REG_EARLY: assert property (@(posedge clk_i) disable iff (srst_i)
      (regulator_sequence_code_i == ldosw_pkg::SEQ_SOFTWARE && !boot_i.at_100)
      |=> !regulator_enable_o)
      else $error("regulator on before full boot delay");
   AST_REG_RESERVED: assert property (@(posedge clk_i) disable iff (srst_i)
      (regulator_sequence_code_i == ldosw_pkg::SEQ_SOFTWARE &&
       regulator_sw_enable_q == 2'h3) |=> !regulator_enable_o)
      else $error("regulator on with reserved value");
   AST_SW_ALWAYS: assert property (@(posedge clk_i) disable iff (srst_i)
      (load_switch_sequence_code_i == ldosw_pkg::SEQ_ALWAYS && supply_present_i)
      |=> load_switch_enable_o)
      else $error("switch open with always code");
   AST_SW_OFF_A: assert property (@(posedge clk_i) disable iff (srst_i)
      (load_switch_sequence_code_i == ldosw_pkg::SEQ_OFF_A) |=> !load_switch_enable_o)
      else $error("switch on with first off code");
   AST_SW_NO_SUPPLY: assert property (@(posedge clk_i) disable iff (srst_i)
      (load_switch_sequence_code_i != ldosw_pkg::SEQ_PIN && !supply_present_i)
      |=> !load_switch_enable_o)
      else $error("switch on without supply");
   AST_SW_QUARTER: assert property (@(posedge clk_i) disable iff (srst_i)
      (load_switch_sequence_code_i == ldosw_pkg::SEQ_AT_25 && supply_present_i)
      |=> load_switch_enable_o == $past(boot_i.at_25))
      else $error("switch not following quarter point");
   AST_SW_EARLY: assert property (@(posedge clk_i) disable iff (srst_i)
      (load_switch_sequence_code_i == ldosw_pkg::SEQ_SOFTWARE && !boot_i.at_100)
      |=> !load_switch_enable_o)
      else $error("switch on before full boot delay");
   AST_SW_ON: assert property (@(posedge clk_i) disable iff (srst_i)
      (load_switch_sequence_code_i == ldosw_pkg::SEQ_SOFTWARE && supply_present_i &&
       boot_i.at_100 && load_switch_sw_enable_q == ldosw_pkg::EN_ON) |=> load_switch_enable_o)
      else $error("switch open with software enable");
   AST_SW_MPC: assert property (@(posedge clk_i) disable iff (srst_i)
      (load_switch_sequence_code_i == ldosw_pkg::SEQ_SOFTWARE && supply_present_i &&
       boot_i.at_100 && load_switch_sw_enable_q == ldosw_pkg::EN_MPC)
      |=> load_switch_enable_o == $past(multipurpose_control_pin_i))
      else $error("switch not following control pin");
   AST_MODE_FOLLOW: assert property (@(posedge clk_i) disable iff (srst_i)
      !reg_en |=> regulator_switch_mode_o == $past(mode_req_q))
      else $error("mode not taken while disabled");
   AST_ACT_DISCHARGE_ON: assert property (@(posedge clk_i) disable iff (srst_i)
      (regulator_active_discharge_q && !regulator_enable_o) |-> regulator_active_discharge_o)
      else $error("no active discharge while disabled");
   AST_OFF_ENTRY: assert property (@(posedge clk_i) disable iff (srst_i)
      off_entry_i |-> (regulator_passive_discharge_o && regulator_active_discharge_o))
      else $error("no discharge on off entry");
   // Read data must fall back to zero so a stale value is never taken twice
   AST_RDATA_IDLE: assert property (@(posedge clk_i) disable iff (srst_i)
      !rd_i |=> rdata_o == 8'h00)
      else $error("read data without read strobe");

   COV_REG_ON: cover property (@(posedge clk_i) disable iff (srst_i) $rose(regulator_enable_o));
   COV_MODE: cover property (@(posedge clk_i) disable iff (srst_i) $rose(regulator_switch_mode_o));
   COV_SOFT: cover property (@(posedge clk_i) disable iff (srst_i)
      $fell(load_switch_current_limit_o) && load_switch_enable_o);
   COV_SOFT_START: cover property (@(posedge clk_i) disable iff (srst_i)
      sw_rise && load_switch_soft_start_q);
   COV_READ: cover property (@(posedge clk_i) disable iff (srst_i) rd_i && sel_reg);
endmodule

// >>> sim/ldosw_ctrl_tb.sv
// Self-checking random testbench for the regulator and load switch enable control
`timescale 1ns/100ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin mismatches++; $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module ldosw_ctrl_tb;
   logic clk_i = 1'b0;
   logic srst_i = 1'b1;
   logic [7:0] addr_i = 8'h00;
   logic [7:0] wdata_i = 8'h00;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic [7:0] rdata_o;
   logic [2:0] rcode = 3'h0;
   logic [2:0] scode = 3'h0;
   ldosw_pkg::ldosw_boot_s boot = '0;
   logic supply = 1'b0;
   logic multipurpose_control_pin = 1'b0;
   logic rpin = 1'b0;
   logic spin = 1'b0;
   logic off_entry = 1'b0;
   logic ren_o, mode_o, uvlo_o, pas_o, act_o, sen_o, lim_o;
   int mismatches = 0;
   int comparisons = 0;
   logic chk_on = 1'b0;
   // Model state: register fields and expected registered outputs
   logic f_pas = 1'b0, f_act = 1'b0, f_mode = 1'b0, f_soft = 1'b0;
   logic [1:0] f_ren = 2'h0, f_sen = 2'h0;
   logic ren_m = 1'b0, sen_m = 1'b0, mode_m = 1'b0, rn, sn;
   logic [7:0] rdata_m = 8'h00;
   logic [7:0] addr_tbl [3] = '{8'h0B, 8'h0C, 8'h3A};

   ldosw_ctrl dut (.clk_i(clk_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .regulator_sequence_code_i(rcode),
      .load_switch_sequence_code_i(scode), .boot_i(boot), .supply_present_i(supply),
      .multipurpose_control_pin_i(multipurpose_control_pin), .regulator_enable_pin_i(rpin),
      .load_switch_enable_pin_i(spin), .off_entry_i(off_entry), .regulator_enable_o(ren_o),
      .regulator_switch_mode_o(mode_o), .regulator_uvlo_bypass_o(uvlo_o),
      .regulator_passive_discharge_o(pas_o), .regulator_active_discharge_o(act_o),
      .load_switch_enable_o(sen_o), .load_switch_current_limit_o(lim_o));

   initial begin
      forever #25 clk_i = ~clk_i;
   end

   // Expected enable before the output register; reserved value 11 counts as off
   function automatic logic sel(input logic [2:0] c, input logic [1:0] en, input logic pin);
      logic sw;
      sw = (en == ldosw_pkg::EN_ON) || ((en == ldosw_pkg::EN_MPC) && multipurpose_control_pin);
      case (c)
         ldosw_pkg::SEQ_ALWAYS: sel = supply;
         ldosw_pkg::SEQ_AT_0: sel = supply & boot.at_0;
         ldosw_pkg::SEQ_AT_25: sel = supply & boot.at_25;
         ldosw_pkg::SEQ_AT_50: sel = supply & boot.at_50;
         ldosw_pkg::SEQ_PIN: sel = pin;
         ldosw_pkg::SEQ_SOFTWARE: sel = supply & boot.at_100 & sw;
         default: sel = 1'b0;
      endcase
   endfunction

   function automatic logic [7:0] readval(input logic [7:0] a);
      // Mode bit reads back the latched value, not the last written one
      if (a == ldosw_pkg::REG_REGULATOR_CONFIG) readval = {rcode, f_pas, f_act, f_ren, mode_m};
      else if (a == ldosw_pkg::REG_LOAD_SWITCH_CONFIG) readval = {scode, 2'h0, f_sen, f_soft};
      else readval = 8'h00;
   endfunction

   // Inputs are steady at the falling edge: check, then predict the next rising edge
   always @(negedge clk_i) begin
      if (chk_on) begin
         `CHK("regulator_enable", ren_m, ren_o)
         `CHK("load_switch_enable", sen_m, sen_o)
         `CHK("switch_mode", mode_m, mode_o)
         `CHK("uvlo_bypass", mode_m & ren_m, uvlo_o)
         `CHK("passive_discharge", off_entry | (f_pas & ~ren_m), pas_o)
         `CHK("active_discharge", off_entry | (f_act & ~ren_m), act_o)
         `CHK("rdata", rdata_m, rdata_o)
      end
      rn = sel(rcode, f_ren, rpin);
      sn = sel(scode, f_sen, spin);
      if (srst_i) begin
         {ren_m, sen_m, mode_m, f_pas, f_act, f_mode, f_soft} = '0;
         {f_ren, f_sen, rdata_m} = '0;
      end else begin
         rdata_m = rd_i ? readval(addr_i) : 8'h00;
         // Mode may only pick up the stored bit while the regulator is off
         if (!rn) mode_m = f_mode;
         ren_m = rn;
         sen_m = sn;
         if (wr_i && addr_i == ldosw_pkg::REG_REGULATOR_CONFIG)
            {f_pas, f_act, f_ren, f_mode} = wdata_i[4:0];
         if (wr_i && addr_i == ldosw_pkg::REG_LOAD_SWITCH_CONFIG)
            {f_sen, f_soft} = wdata_i[2:0];
      end
   end

   task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask

   task automatic final_report;
      if (mismatches == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   initial begin
      repeat (10000) @(posedge clk_i);
      mismatches++;
      final_report();
   end

   initial begin
      int r;
      void'($urandom(50));
      repeat (6) @(posedge clk_i);
      srst_i <= 1'b0;
      @(negedge clk_i);
      chk_on = 1'b1;
      for (int i = 0; i < 3000; i++) begin
         @(posedge clk_i);
         // Mid-run reset must clear every field and every output again, except the discharge outputs, which follow off_entry
         srst_i <= (i >= 1500 && i < 1503);
         r = $urandom % 8;
         wr_i <= (r < 2);
         rd_i <= (r == 2 || r == 3);
         addr_i <= addr_tbl[$urandom % 3];
         wdata_i <= 8'($urandom);
         if ($urandom % 4 == 0) begin
            rcode <= 3'($urandom);
            scode <= 3'($urandom);
            boot <= 4'($urandom);
         end
         supply <= ($urandom % 8 != 0);
         {multipurpose_control_pin, rpin, spin} <= 3'($urandom);
         off_entry <= ($urandom % 16 == 0);
      end
      @(posedge clk_i);
      {wr_i, rd_i, off_entry} <= '0;
      // Soft start: limit must stand while the switch is on, then drop with it
      scode <= ldosw_pkg::SEQ_SOFTWARE;
      supply <= 1'b1;
      boot <= 4'hF;
      bus_wr(ldosw_pkg::REG_LOAD_SWITCH_CONFIG, 8'h00);
      bus_wr(ldosw_pkg::REG_LOAD_SWITCH_CONFIG, 8'h03);
      repeat (3) @(negedge clk_i);
      repeat (8) begin
         @(negedge clk_i);
         `CHK("current_limit_on", 1'b1, lim_o)
      end
      bus_wr(ldosw_pkg::REG_LOAD_SWITCH_CONFIG, 8'h01);
      repeat (3) @(negedge clk_i);
      `CHK("current_limit_drop", 1'b0, lim_o)
      bus_wr(ldosw_pkg::REG_LOAD_SWITCH_CONFIG, 8'h02);
      repeat (3) @(negedge clk_i);
      `CHK("switch_on_no_soft", 1'b1, sen_o)
      `CHK("current_limit_off", 1'b0, lim_o)
      final_report();
   end
endmodule
